// ==== hw/aphs_top.sv ====
// position readout and hole pattern sequencer for a milling display
// assumes scale, keypad and entry inputs synchronous to sys_clk,
// keys as one-cycle pulses, an outside nonvolatile store and an
// outside hole coordinate generator fed from the program outputs
`include "aphs_cfg.svh"

module aphs_top #(
	parameter logic [31:0] BRIEF_CYC = `APHS_BRIEF_CYC
) (
	// clock and reset
	input  wire logic                                      sys_clk,
	input  wire logic                                      sys_rst,
	// scales and their setup
	input  wire logic [`APHS_NAX-1:0]                      scale_a,
	input  wire logic [`APHS_NAX-1:0]                      scale_b,
	input  wire logic [`APHS_NAX-1:0]                      dir_neg,
	input  wire logic [`APHS_NAX-1:0]                      dia_en,
	// keypad
	input  wire logic                                      key_ref,
	input  wire logic                                      key_sign,
	input  wire logic                                      key_next,
	input  wire logic                                      key_start,
	input  wire logic                                      key_menu,
	input  wire logic                                      key_clear,
	input  wire logic [`APHS_NAX-1:0]                      key_axis,
	// numeric entry
	input  wire logic                                      entry_we,
	input  wire logic [1:0]                                entry_axis,
	input  wire aphs_pkg::aphs_word_t                      entry_val,
	// nonvolatile store
	input  wire logic                                      nv_restore,
	input  wire aphs_pkg::aphs_word_t [1:0][3:0]           nv_prog_in,
	output      aphs_pkg::aphs_word_t [1:0][3:0]           prog,
	output      logic                                      nv_save,
	// hole coordinate generator
	input  wire aphs_pkg::aphs_word_t                      hole_x,
	input  wire aphs_pkg::aphs_word_t                      hole_y,
	output      logic [`APHS_CNT_W-1:0]                    hole_index,
	output      logic                                      full_circle,
	output      logic                                      pattern_kind,
	// display
	output      aphs_pkg::aphs_word_t [`APHS_NAX-1:0]      disp_val,
	output      logic                                      led_abs,
	output      logic                                      led_rel1,
	output      logic                                      led_rel2,
	output      aphs_pkg::aphs_mode_t                      mode_state,
	output      logic [1:0]                                param_screen
);
	import aphs_pkg::*;

	aphs_state_t r_reg;
	aphs_state_t r_next;
	logic        readout;
	logic        in_pat;
	logic        leave;

	// one signed step from a quadrature transition
	function automatic aphs_word_t aphs_step(input logic [3:0] t,
		input logic neg, input logic dia);
		logic signed [2:0] d;
		d = 3'sh0;
		case (t)
			4'h1, 4'h7, 4'hE, 4'h8: d = 3'sh1;
			4'h2, 4'hB, 4'hD, 4'h4: d = 3'sh7;
			default: d = 3'sh0;
		endcase
		if (neg) begin
			d = -d;
		end
		if (dia) begin
			d = d <<< 1;
		end
		return aphs_word_t'(d);
	endfunction

	// clamp a hole count into its legal range
	function automatic aphs_word_t aphs_clamp(input aphs_word_t v);
		aphs_word_t lo;
		aphs_word_t hi;
		lo = aphs_word_t'(`APHS_HOLES_MIN);
		hi = aphs_word_t'(`APHS_HOLES_MAX);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// states in which the readout keys and presets act
	assign readout = (r_reg.st == ST_NOR) || (r_reg.st == ST_PROMPT) ||
		(r_reg.st == ST_READY) || (r_reg.st == ST_COORD);
	assign in_pat = (r_reg.st != ST_NOR) && (r_reg.st != ST_MENU);
	assign leave = key_menu || key_clear;

	// next state
	always_comb begin
		aphs_word_t dl;
		logic [1:0] sel;
		dl = '0;
		sel = `APHS_SEL_ABS;
		r_next = r_reg;
		r_next.nv_save = 1'b0;

		// every register of an axis moves with its scale
		for (int a = 0; a < `APHS_NAX; a++) begin
			dl = aphs_step({r_reg.qa[a], r_reg.qb[a], scale_a[a], scale_b[a]},
				dir_neg[a], dia_en[a]);
			r_next.qa[a] = scale_a[a];
			r_next.qb[a] = scale_b[a];
			for (int s = 0; s < 3; s++) begin
				r_next.pos[a][s] = r_reg.pos[a][s] + dl;
			end
		end

		// view keys
		if (readout && key_ref) begin
			r_next.v_abs = ~r_reg.v_abs;
		end
		if (readout && key_sign && !r_reg.v_abs) begin
			r_next.v_rel2 = ~r_reg.v_rel2;
		end

		// restore of the stored programs after power-up
		if (nv_restore) begin
			r_next.prog = nv_prog_in;
			for (int k = 0; k < 2; k++) begin
				r_next.prog[k][3] = aphs_clamp(nv_prog_in[k][3]);
			end
		end

		// operating sequence
		if (in_pat && leave) begin
			r_next.st = ST_NOR;
		end else begin
			unique case (r_reg.st)
				ST_NOR: begin
					if (key_menu) begin
						r_next.st = ST_MENU;
						r_next.page = 2'h0;
					end
				end
				ST_MENU: begin
					if (leave) begin
						r_next.st = ST_NOR;
					end else if (key_next) begin
						r_next.page = r_reg.page + 2'h1;
					end else if (r_reg.page == `APHS_MENU_PAT &&
						key_axis[1:0] != 2'h0) begin
						r_next.st = ST_EDIT;
						r_next.kind = key_axis[1];
						r_next.scr = `APHS_P_SIZE;
					end
				end
				ST_EDIT: begin
					if (key_start) begin
						r_next.st = ST_PROMPT;
						r_next.tmr = BRIEF_CYC - 32'h1;
					end else if (key_next) begin
						if (r_reg.scr == `APHS_P_HOLES) begin
							r_next.st = ST_STORED;
							r_next.nv_save = 1'b1;
						end else if (r_reg.kind == `APHS_KIND_LINE &&
							r_reg.scr == `APHS_P_ANG0) begin
							r_next.scr = `APHS_P_HOLES;
						end else begin
							r_next.scr = r_reg.scr + 2'h1;
						end
					end else if (entry_we) begin
						r_next.prog[r_reg.kind][r_reg.scr] = entry_val;
						if (r_reg.scr == `APHS_P_HOLES) begin
							r_next.prog[r_reg.kind][r_reg.scr] =
								aphs_clamp(entry_val);
						end
					end
				end
				ST_STORED: begin
					if (key_next) begin
						r_next.st = ST_PROMPT;
						r_next.tmr = BRIEF_CYC - 32'h1;
					end
				end
				ST_PROMPT: begin
					if (r_reg.tmr == 32'h0) begin
						r_next.st = ST_READY;
						r_next.idx = '0;
					end else begin
						r_next.tmr = r_reg.tmr - 32'h1;
					end
				end
				ST_READY, ST_COORD: begin
					if (key_next) begin
						r_next.st = ST_HOLE;
						r_next.tmr = BRIEF_CYC - 32'h1;
						// wrap so the pattern can be run again
						if (r_reg.idx ==
							r_reg.prog[r_reg.kind][3][`APHS_CNT_W-1:0]) begin
							r_next.idx = `APHS_HOLES_MIN;
						end else begin
							r_next.idx = r_reg.idx + `APHS_CNT_W'(1);
						end
					end
				end
				ST_HOLE: begin
					if (r_reg.tmr == 32'h0) begin
						r_next.st = ST_COORD;
						// relative view counts down to the hole
						r_next.pos[0][1] = r_next.pos[0][0] - hole_x;
						r_next.pos[1][1] = r_next.pos[1][0] - hole_y;
						r_next.v_abs = 1'b0;
						r_next.v_rel2 = 1'b0;
					end else begin
						r_next.tmr = r_reg.tmr - 32'h1;
					end
				end
			endcase
		end

		// preset into the shown register only
		sel = r_reg.v_abs ? `APHS_SEL_ABS :
			(r_reg.v_rel2 ? `APHS_SEL_REL2 : `APHS_SEL_REL1);
		if (readout && entry_we) begin
			r_next.pos[entry_axis][sel] = entry_val;
		end

		// display and indicators follow the next view
		sel = r_next.v_abs ? `APHS_SEL_ABS :
			(r_next.v_rel2 ? `APHS_SEL_REL2 : `APHS_SEL_REL1);
		r_next.leds = {r_next.v_rel2 & ~r_next.v_abs,
			~r_next.v_rel2 & ~r_next.v_abs, r_next.v_abs};
		for (int a = 0; a < `APHS_NAX; a++) begin
			r_next.disp[a] = r_next.pos[a][sel];
		end
		r_next.full = (r_next.prog[0][1] == r_next.prog[0][2]);
	end

	// state register, defaults loaded at reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.st <= ST_NOR;
			r_reg.v_abs <= 1'b1;
			r_reg.leds <= 3'h1;
			r_reg.full <= 1'b1;
			r_reg.prog[0][0] <= `APHS_DEF_RADIUS;
			r_reg.prog[0][1] <= `APHS_DEF_START;
			r_reg.prog[0][2] <= `APHS_DEF_END;
			r_reg.prog[0][3] <= `APHS_DEF_HOLES;
			r_reg.prog[1][0] <= `APHS_DEF_LEN;
			r_reg.prog[1][1] <= `APHS_DEF_LANG;
			r_reg.prog[1][3] <= `APHS_DEF_HOLES;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign prog = r_reg.prog;
	assign nv_save = r_reg.nv_save;
	assign hole_index = r_reg.idx;
	assign full_circle = r_reg.full;
	assign pattern_kind = r_reg.kind;
	assign disp_val = r_reg.disp;
	assign led_abs = r_reg.leds[0];
	assign led_rel1 = r_reg.leds[1];
	assign led_rel2 = r_reg.leds[2];
	assign mode_state = r_reg.st;
	assign param_screen = r_reg.scr;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// helper: a preset was taken this cycle
	logic pres_now;
	assign pres_now = readout && entry_we;

	equal_motion_a: assert property (
		!pres_now && r_reg.st != ST_HOLE |=>
		(r_reg.pos[2][0] - $past(r_reg.pos[2][0])) ==
		(r_reg.pos[2][1] - $past(r_reg.pos[2][1])) &&
		(r_reg.pos[2][0] - $past(r_reg.pos[2][0])) ==
		(r_reg.pos[2][2] - $past(r_reg.pos[2][2])))
		else $error("registers of one axis moved apart");

	preset_only_a: assert property (
		pres_now && !r_reg.v_abs && entry_axis == 2'h2 |=>
		r_reg.pos[2][0] - $past(r_reg.pos[2][0]) ==
		aphs_step({$past(r_reg.qa[2]), $past(r_reg.qb[2]),
		$past(scale_a[2]), $past(scale_b[2])},
		$past(dir_neg[2]), $past(dia_en[2])))
		else $error("preset disturbed the datum register");

	ref_toggle_a: assert property (
		r_reg.st == ST_NOR && key_ref |=>
		led_abs != $past(led_abs) && $onehot(r_reg.leds))
		else $error("reference key did not switch view");

	sign_toggle_a: assert property (
		r_reg.st == ST_NOR && key_sign && !key_ref && !r_reg.v_abs |=>
		led_rel2 != $past(led_rel2) && !led_abs)
		else $error("sign key did not swap relative view");

	count_range_a: assert property (
		r_reg.prog[0][3] >= 32'h1 && r_reg.prog[0][3] <= 32'h270F &&
		r_reg.prog[1][3] >= 32'h1 && r_reg.prog[1][3] <= 32'h270F)
		else $error("hole count out of range");

	menu_enter_a: assert property (
		r_reg.st == ST_MENU && !leave && !key_next && r_reg.page == 2'h0 &&
		key_axis[0] && !key_axis[1] |=>
		r_reg.st == ST_EDIT && r_reg.kind == 1'b0 && r_reg.scr == 2'h0)
		else $error("axis key did not enter circular mode");

	save_pulse_a: assert property (
		nv_save |-> r_reg.st == ST_STORED && $past(r_reg.st) == ST_EDIT
		##1 !nv_save)
		else $error("store pulse out of place");

	exit_mode_a: assert property (
		in_pat && key_clear |=> r_reg.st == ST_NOR)
		else $error("clear key did not leave pattern mode");

	prompt_end_a: assert property (
		r_reg.st == ST_PROMPT && r_reg.tmr == 32'h0 && !leave |=>
		r_reg.st == ST_READY && r_reg.idx == '0)
		else $error("prompt did not end at its count");

	hole_wrap_a: assert property (
		r_reg.st == ST_COORD && key_next && !leave &&
		r_reg.idx == r_reg.prog[r_reg.kind][3][`APHS_CNT_W-1:0] |=>
		r_reg.st == ST_HOLE && r_reg.idx == 14'h0001)
		else $error("hole index did not wrap");

	preload_a: assert property (
		r_reg.st == ST_HOLE && r_reg.tmr == 32'h0 && !leave |=>
		r_reg.pos[0][1] + $past(hole_x) == r_reg.pos[0][0] &&
		r_reg.st == ST_COORD && led_rel1)
		else $error("hole offset not preloaded");

endmodule // aphs_top

// ==== hw/aphs_cfg.svh ====
// constants for the axis position and hole sequencer
// assumes inclusion by bare name from the package and the top module
`ifndef APHS_CFG_SVH
`define APHS_CFG_SVH

// widths
`define APHS_NAX        3
`define APHS_POS_W      32
`define APHS_CNT_W      14

// hole count limits
`define APHS_HOLES_MIN  14'h0001
`define APHS_HOLES_MAX  14'h270F

// program parameter slots (line programs skip the end angle slot)
`define APHS_P_SIZE     2'h0
`define APHS_P_ANG0     2'h1
`define APHS_P_ANG1     2'h2
`define APHS_P_HOLES    2'h3

// position register select
`define APHS_SEL_ABS    2'h0
`define APHS_SEL_REL1   2'h1
`define APHS_SEL_REL2   2'h2

// program kinds and the menu page that offers them
`define APHS_KIND_CIRC  1'h0
`define APHS_KIND_LINE  1'h1
`define APHS_MENU_PAT   2'h0

// default programs, lengths and angles in 0.0001 units
`define APHS_DEF_RADIUS 32'h00001388
`define APHS_DEF_START  32'h000DBBA0
`define APHS_DEF_END    32'h000DBBA0
`define APHS_DEF_HOLES  32'h00000004
`define APHS_DEF_LEN    32'h00003A98
`define APHS_DEF_LANG   32'h0006DDD0

// timing of the brief screens
`define APHS_CLK_HZ     40000000
`define APHS_BRIEF_MS   500
`define APHS_BRIEF_CYC  (`APHS_BRIEF_MS * (`APHS_CLK_HZ / 1000))

`endif

// ==== hw/aphs_pkg.sv ====
// types for the axis position and hole sequencer
// assumes aphs_cfg.svh sits on the include path
package aphs_pkg;
`include "aphs_cfg.svh"

	typedef logic [`APHS_POS_W-1:0] aphs_word_t;

	// operating states, one-hot
	typedef enum logic [7:0] {
		ST_NOR    = 8'h01,
		ST_MENU   = 8'h02,
		ST_EDIT   = 8'h04,
		ST_STORED = 8'h08,
		ST_PROMPT = 8'h10,
		ST_READY  = 8'h20,
		ST_HOLE   = 8'h40,
		ST_COORD  = 8'h80
	} aphs_mode_t;

	// whole state of the block
	typedef struct packed {
		aphs_mode_t                      st;
		logic                            kind;
		logic [1:0]                      scr;
		logic [1:0]                      page;
		logic                            v_abs;
		logic                            v_rel2;
		logic [2:0]                      leds;
		logic [`APHS_NAX-1:0]            qa;
		logic [`APHS_NAX-1:0]            qb;
		aphs_word_t [`APHS_NAX-1:0][2:0] pos;
		aphs_word_t [1:0][3:0]           prog;
		logic [`APHS_CNT_W-1:0]          idx;
		logic [31:0]                     tmr;
		logic                            nv_save;
		logic                            full;
		aphs_word_t [`APHS_NAX-1:0]      disp;
	} aphs_state_t;

endpackage

// ==== tb/aphs_scale_model.sv ====
// quadrature scale model for the three axes
// assumes step requests from the bench, one step per held clock
module aphs_scale_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// step requests
	input  wire logic [2:0] step_req,
	input  wire logic       step_dn,
	// scale lines
	output logic      [2:0] scale_a,
	output logic      [2:0] scale_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_reg [3];

	// phase moves one place per edge, so no quadrature state is skipped
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		for (int i = 0; i < 3; i++) begin
			if (sys_rst)
				ph_reg[i] <= 2'h0;
			else if (step_req[i])
				ph_reg[i] <= step_dn ? ph_reg[i] - 2'h1 : ph_reg[i] + 2'h1;
		end
	end

	// gray order 00 01 11 10 forward, one line changes per step
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			scale_a[i] = ph_reg[i][1];
			scale_b[i] = ph_reg[i][1] ^ ph_reg[i][0];
		end
	end
endmodule // aphs_scale_model

// ==== tb/test_axis_position_hole_sequencer.sv ====
// self-checking bench for the position readout and hole sequencer
// assumes the scale model beside it and a short brief-screen count
`include "aphs_cfg.svh"
module test_axis_position_hole_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import aphs_pkg::*;
	logic sys_clk = 0, sys_rst = 1, step_dn = 0, entry_we = 0;
	logic nv_restore = 0, nv_save, full_circle, pattern_kind;
	logic led_abs, led_rel1, led_rel2;
	logic [2:0] step_req = 0, scale_a, scale_b, dir_neg = 0, dia_en = 0;
	logic [8:0] keys = 0;
	logic [1:0] entry_axis = 0, param_screen;
	logic [13:0] hole_index;
	aphs_word_t entry_val = 0, hole_x = 32'h10, hole_y = 32'h20;
	aphs_word_t [1:0][3:0] nv_prog_in = '0, prog;
	aphs_word_t [2:0] disp_val;
	aphs_mode_t mode_state;
	int mismatches = 0, total_checks = 0, cycles = 0;

	aphs_scale_model i_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.step_req(step_req), .step_dn(step_dn), .scale_a(scale_a),
		.scale_b(scale_b));
	// key order: ref sign next start menu clear, then axis x y z
	aphs_top #(.BRIEF_CYC(32'h4)) i_dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .scale_a(scale_a), .scale_b(scale_b),
		.dir_neg(dir_neg), .dia_en(dia_en), .key_ref(keys[0]),
		.key_sign(keys[1]), .key_next(keys[2]), .key_start(keys[3]),
		.key_menu(keys[4]), .key_clear(keys[5]), .key_axis(keys[8:6]),
		.entry_we(entry_we), .entry_axis(entry_axis),
		.entry_val(entry_val), .nv_restore(nv_restore),
		.nv_prog_in(nv_prog_in), .prog(prog), .nv_save(nv_save),
		.hole_x(hole_x), .hole_y(hole_y), .hole_index(hole_index),
		.full_circle(full_circle), .pattern_kind(pattern_kind),
		.disp_val(disp_val), .led_abs(led_abs), .led_rel1(led_rel1),
		.led_rel2(led_rel2), .mode_state(mode_state),
		.param_screen(param_screen));

	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// hang guard, the whole run needs under two hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic press(input int k);
		@(posedge sys_clk) keys[k] <= 1'b1;
		@(posedge sys_clk) keys <= '0;
		#1;
	endtask
	task automatic enter(input logic [1:0] ax, input aphs_word_t v);
		@(posedge sys_clk) begin
			entry_we <= 1'b1;
			entry_axis <= ax;
			entry_val <= v;
		end
		@(posedge sys_clk) entry_we <= 1'b0;
		#1;
	endtask
	// held request gives n steps; disp lags the scale by one edge
	task automatic move(input int ax, input logic dn, input int n);
		@(posedge sys_clk) begin
			step_req <= 3'h1 << ax;
			step_dn <= dn;
		end
		repeat (n) @(posedge sys_clk);
		step_req <= 3'h0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic wait_mode(input aphs_mode_t m);
		for (int i = 0; i < 20 && mode_state !== m; i++)
			@(posedge sys_clk) #1;
		check(mode_state, m);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic test_reset();
		check({led_abs, led_rel1, led_rel2}, 3'h4);
		check(mode_state, ST_NOR);
		check(prog[0][0], `APHS_DEF_RADIUS);
		check(prog[0][1], `APHS_DEF_START);
		check(prog[0][2], `APHS_DEF_END);
		check(prog[0][3], 32'h4);
		check(prog[1][0], `APHS_DEF_LEN);
		check(prog[1][1], `APHS_DEF_LANG);
		check(prog[1][3], 32'h4);
		check(full_circle, 1'b1);
	endtask
	task automatic test_views();
		move(0, 1'b0, 4);
		check(disp_val[0], 32'h4);
		press(0);
		check({led_abs, led_rel1, led_rel2}, 3'h2);
		check(disp_val[0], 32'h4);
		press(1);
		check({led_abs, led_rel1, led_rel2}, 3'h1);
		check(disp_val[0], 32'h4);
		enter(2'h0, 32'h100);
		check(disp_val[0], 32'h100);
		// a preset on z must leave its unmoved datum at zero
		enter(2'h2, 32'h55);
		check(disp_val[2], 32'h55);
		press(1);
		check(disp_val[0], 32'h4);
		press(0);
		check(disp_val[0], 32'h4);
		check(disp_val[2], 32'h0);
		@(posedge sys_clk) begin
			dir_neg[1] <= 1'b1;
			dia_en[1] <= 1'b1;
		end
		move(1, 1'b0, 1);
		check(disp_val[1], 32'hFFFFFFFE);
	endtask
	task automatic test_circle();
		press(4);
		press(2);
		press(6);
		check(mode_state, ST_MENU);
		repeat (3) press(2);
		press(6);
		check(mode_state, ST_EDIT);
		check(pattern_kind, 1'b0);
		for (int s = 1; s < 4; s++) begin
			press(2);
			check(param_screen, s);
			// unequal end angle turns the pattern into an arc
			if (s == 2) begin
				enter(2'h0, 32'h0);
				check(full_circle, 1'b0);
			end
		end
		enter(2'h0, 32'h0);
		check(prog[0][3], 32'h1);
		enter(2'h0, 32'h2710);
		check(prog[0][3], `APHS_HOLES_MAX);
		press(2);
		check({mode_state, nv_save}, {ST_STORED, 1'b1});
		press(2);
		check(mode_state, ST_PROMPT);
		wait_mode(ST_READY);
		for (int h = 1; h < 3; h++) begin
			press(2);
			check({mode_state, hole_index}, {ST_HOLE, 14'(h)});
			wait_mode(ST_COORD);
			check(disp_val[0], 32'hFFFFFFF4);
			check(disp_val[1], 32'hFFFFFFDE);
		end
		press(5);
		check(mode_state, ST_NOR);
	endtask
	task automatic test_line();
		press(4);
		press(7);
		check({mode_state, pattern_kind}, {ST_EDIT, 1'b1});
		press(2);
		press(2);
		check(param_screen, 2'h3);
		press(3);
		check(mode_state, ST_PROMPT);
		wait_mode(ST_READY);
		// default line count is 4, so the fifth step wraps to hole 1
		for (int h = 1; h < 6; h++) begin
			press(2);
			check(hole_index, (h - 1) % 4 + 1);
			wait_mode(ST_COORD);
		end
		press(4);
		check(mode_state, ST_NOR);
		@(posedge sys_clk) begin
			nv_prog_in[0][0] <= 32'h1234;
			nv_restore <= 1'b1;
		end
		@(posedge sys_clk) nv_restore <= 1'b0;
		#1;
		check(prog[0][0], 32'h1234);
		check(prog[1][3], 32'h1);
		check(full_circle, 1'b1);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		test_reset();
		test_views();
		test_circle();
		test_line();
		print_verdict();
	end
endmodule // test_axis_position_hole_sequencer
